// [bba_pkg.sv]
// package: opcodes, flag layout, register map and bus constants for the adder datapath
package bba_pkg;
    // ------------------------------------------------------------
    // function codes
    // ------------------------------------------------------------
    localparam logic [11:0] OP_ADD_S = 12'h400;
    localparam logic [11:0] OP_ADD_D = 12'h401;
    localparam logic [11:0] OP_ADC_S = 12'h402;
    localparam logic [11:0] OP_ADC_D = 12'h403;
    localparam logic [11:0] OP_BCD_S = 12'h404;
    localparam logic [11:0] OP_BCD_D = 12'h405;
    localparam logic [11:0] OP_BCDC_S = 12'h406;
    localparam logic [11:0] OP_BCDC_D = 12'h407;
    localparam logic [11:0] OP_SUB_S = 12'h410;
    localparam logic [11:0] OP_SUB_D = 12'h411;
    localparam logic [11:0] OP_CLC = 12'h041;
    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_OPND_A = 8'h00;
    localparam logic [7:0] ADDR_OPND_B = 8'h04;
    localparam logic [7:0] ADDR_CMD = 8'h08;
    localparam logic [7:0] ADDR_RESULT = 8'h0C;
    localparam logic [7:0] ADDR_FLAGS = 8'h10;
    // ------------------------------------------------------------
    // command and flag fields
    // ------------------------------------------------------------
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_EDGE_BIT = 12;
    localparam int CMD_COND_BIT = 13;
    localparam int FLG_ERR = 0;
    localparam int FLG_ZERO = 1;
    localparam int FLG_CARRY = 2;
    localparam int FLG_OVF = 3;
    localparam int FLG_UNF = 4;
    localparam int FLG_NEG = 5;
    localparam int FLG_BADOP = 6;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef struct packed {
        logic neg;
        logic unf;
        logic ovf;
        logic carry;
        logic zero;
        logic err;
    } bba_flags_t;

    typedef struct packed {
        logic [31:0] sum;
        bba_flags_t flags;
    } bba_alu_out_t;
endpackage

// [bba_bcd_digit.sv]
// one packed-decimal digit adder with validity check
`timescale 1ns/1ps
module bba_bcd_digit (
    input wire logic [3:0] a,
    input wire logic [3:0] b,
    input wire logic cin,
    output logic [3:0] sum,
    output logic cout,
    output logic bad
);
    logic [4:0] raw;
    logic [4:0] fixed;
    always_comb begin
        raw = {1'b0, a} + {1'b0, b} + {4'h0, cin};
        // decimal correction above nine
        cout = (raw > 5'h09);
        fixed = cout ? (raw + 5'h06) : raw;
        sum = fixed[3:0];
        bad = (a > 4'h9) || (b > 4'h9);
    end
endmodule // bba_bcd_digit

// [bba_bin_adder.sv]
// signed binary adder for one or two words with flag derivation
`timescale 1ns/1ps
module bba_bin_adder (
    input wire logic [31:0] a,
    input wire logic [31:0] b,
    input wire logic cin,
    input wire logic dbl,
    output bba_pkg::bba_alu_out_t res
);
    import bba_pkg::*;
    logic [32:0] s;
    logic sa;
    logic sb;
    logic sr;
    always_comb begin
        res = '0;
        sa = dbl ? a[31] : a[15];
        sb = dbl ? b[31] : b[15];
        if (dbl) begin
            s = {1'b0, a} + {1'b0, b} + {32'h0, cin};
            res.sum = s[31:0];
            res.flags.carry = s[32];
            sr = s[31];
        end else begin
            s = {17'h0, a[15:0]} + {17'h0, b[15:0]} + {32'h0, cin};
            res.sum = {16'h0, s[15:0]};
            res.flags.carry = s[16];
            sr = s[15];
        end
        res.flags.zero = (res.sum == 32'h0);
        res.flags.ovf = !sa && !sb && sr;
        res.flags.unf = sa && sb && !sr;
        res.flags.neg = sr;
        res.flags.err = 1'b0;
    end
endmodule // bba_bin_adder

// [bba_adder_top.sv]
// add-instruction datapath with flag register behind an AHB-Lite slave
//
// Register access over AHB-Lite and the address map were decided locally.
`timescale 1ns/1ps
module bba_adder_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic sub_decoded
);
    import bba_pkg::*;

    // ------------------------------------------------------------
    // bus address phase capture
    // ------------------------------------------------------------
    logic wr_pend_ff;
    logic nxt_wr_pend;
    logic [7:0] addr_ff;
    logic [7:0] nxt_addr;
    logic take;
    always_comb begin
        take = hsel && hready && (htrans == HTRANS_NONSEQ) && (hsize == HSIZE_WORD);
        nxt_wr_pend = take && hwrite;
        nxt_addr = take ? haddr : addr_ff;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            addr_ff <= 8'h00;
        end else if (clk_en) begin
            wr_pend_ff <= nxt_wr_pend;
            addr_ff <= nxt_addr;
        end
    end
    // zero wait states; response is always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ------------------------------------------------------------
    // operand, command and condition state
    // ------------------------------------------------------------
    logic [31:0] opa_ff;
    logic [31:0] opb_ff;
    logic [31:0] nxt_opa;
    logic [31:0] nxt_opb;
    logic [11:0] op_ff;
    logic [11:0] nxt_op;
    logic edge_ff;
    logic nxt_edge;
    logic cond_ff;
    logic nxt_cond;
    logic cond_prev_ff;
    logic nxt_cond_prev;
    logic cmd_wr;
    logic fire;
    always_comb begin
        nxt_opa = opa_ff;
        nxt_opb = opb_ff;
        nxt_op = op_ff;
        nxt_edge = edge_ff;
        nxt_cond = cond_ff;
        cmd_wr = 1'b0;
        if (wr_pend_ff) begin
            unique case (addr_ff)
                ADDR_OPND_A: nxt_opa = hwdata;
                ADDR_OPND_B: nxt_opb = hwdata;
                ADDR_CMD: begin
                    cmd_wr = 1'b1;
                    nxt_op = hwdata[CMD_OP_LSB +: 12];
                    nxt_edge = hwdata[CMD_EDGE_BIT];
                    nxt_cond = hwdata[CMD_COND_BIT];
                end
                default: cmd_wr = 1'b0;
            endcase
        end
        // each command write is one scan of the execution condition
        nxt_cond_prev = cmd_wr ? nxt_cond : cond_prev_ff;
        fire = cmd_wr && nxt_cond && (!nxt_edge || !cond_prev_ff);
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            opa_ff <= RESET_WORD;
            opb_ff <= RESET_WORD;
            op_ff <= 12'h000;
            edge_ff <= 1'b0;
            cond_ff <= 1'b0;
            cond_prev_ff <= 1'b0;
        end else if (clk_en) begin
            opa_ff <= nxt_opa;
            opb_ff <= nxt_opb;
            op_ff <= nxt_op;
            edge_ff <= nxt_edge;
            cond_ff <= nxt_cond;
            cond_prev_ff <= nxt_cond_prev;
        end
    end

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic is_bin;
    logic is_bcd;
    logic use_cy;
    logic dbl;
    logic is_clc;
    logic is_sub;
    logic [31:0] wa;
    logic [31:0] wb;
    bba_flags_t flags_ff;
    bba_flags_t nxt_flags;
    always_comb begin
        is_bin = (nxt_op == OP_ADD_S) || (nxt_op == OP_ADD_D) || (nxt_op == OP_ADC_S) || (nxt_op == OP_ADC_D);
        is_bcd = (nxt_op == OP_BCD_S) || (nxt_op == OP_BCD_D) || (nxt_op == OP_BCDC_S) || (nxt_op == OP_BCDC_D);
        use_cy = (nxt_op == OP_ADC_S) || (nxt_op == OP_ADC_D) || (nxt_op == OP_BCDC_S) || (nxt_op == OP_BCDC_D);
        dbl = nxt_op[0];
        is_clc = (nxt_op == OP_CLC);
        is_sub = (nxt_op == OP_SUB_S) || (nxt_op == OP_SUB_D);
        // operands written together with the command are used at once
        wa = nxt_opa;
        wb = nxt_opb;
    end

    // ------------------------------------------------------------
    // binary and decimal adders
    // ------------------------------------------------------------
    bba_alu_out_t bin_res;
    bba_bin_adder u_bin (
        .a(wa),
        .b(wb),
        .cin(use_cy && flags_ff.carry),
        .dbl(dbl),
        .res(bin_res)
    );

    wire logic [8:0] dc;
    wire logic [31:0] dsum;
    wire logic [7:0] dbad;
    assign dc[0] = use_cy && flags_ff.carry;
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_dig
            bba_bcd_digit u_dig (
                .a(wa[gi*4 +: 4]),
                .b(wb[gi*4 +: 4]),
                .cin(dc[gi]),
                .sum(dsum[gi*4 +: 4]),
                .cout(dc[gi+1]),
                .bad(dbad[gi])
            );
        end
    endgenerate

    bba_alu_out_t bcd_res;
    always_comb begin
        bcd_res = '0;
        if (dbl) begin
            bcd_res.sum = dsum;
            bcd_res.flags.carry = dc[8];
            bcd_res.flags.err = |dbad;
        end else begin
            bcd_res.sum = {16'h0, dsum[15:0]};
            bcd_res.flags.carry = dc[4];
            bcd_res.flags.err = |dbad[3:0];
        end
        bcd_res.flags.zero = (bcd_res.sum == 32'h0);
    end

    // ------------------------------------------------------------
    // result and flag update
    // ------------------------------------------------------------
    logic [31:0] result_ff;
    logic [31:0] nxt_result;
    logic sub_ff;
    logic nxt_sub;
    logic badop_ff;
    logic nxt_badop;
    always_comb begin
        nxt_result = result_ff;
        nxt_flags = flags_ff;
        nxt_sub = sub_ff;
        nxt_badop = badop_ff;
        if (fire) begin
            nxt_sub = is_sub;
            nxt_badop = !(is_bin || is_bcd || is_clc || is_sub);
            if (is_bin) begin
                nxt_result = bin_res.sum;
                nxt_flags = bin_res.flags;
            end else if (is_bcd) begin
                // overflow and underflow are left as they were for decimal adds
                nxt_result = bcd_res.sum;
                nxt_flags.err = bcd_res.flags.err;
                nxt_flags.zero = bcd_res.flags.zero;
                nxt_flags.carry = bcd_res.flags.carry;
            end else if (is_clc) begin
                nxt_flags.carry = 1'b0;
            end
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            result_ff <= RESET_WORD;
            flags_ff <= '0;
            sub_ff <= 1'b0;
            badop_ff <= 1'b0;
        end else if (clk_en) begin
            result_ff <= nxt_result;
            flags_ff <= nxt_flags;
            sub_ff <= nxt_sub;
            badop_ff <= nxt_badop;
        end
    end
    assign sub_decoded = sub_ff;

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    always_comb begin
        unique case (haddr)
            ADDR_OPND_A: nxt_rdata = opa_ff;
            ADDR_OPND_B: nxt_rdata = opb_ff;
            ADDR_CMD: nxt_rdata = {18'h0, cond_ff, edge_ff, op_ff};
            ADDR_RESULT: nxt_rdata = result_ff;
            ADDR_FLAGS: nxt_rdata = {25'h0, badop_ff, flags_ff.neg, flags_ff.unf, flags_ff.ovf,
                                     flags_ff.carry, flags_ff.zero, flags_ff.err};
            default: nxt_rdata = 32'h0;
        endcase
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_ff <= RESET_WORD;
        end else if (clk_en) begin
            rdata_ff <= (take && !hwrite) ? nxt_rdata : rdata_ff;
        end
    end
    assign hrdata = rdata_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // width of the command that ran, seen one cycle later
    logic dbl_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dbl_q <= 1'b0;
        end else if (clk_en) begin
            dbl_q <= dbl;
        end
    end

    // all eight result nibbles are decimal digits
    logic res_dec_ok;
    always_comb begin
        res_dec_ok = 1'b1;
        for (int i = 0; i < 8; i++) begin
            if (result_ff[i*4 +: 4] > 4'h9) begin
                res_dec_ok = 1'b0;
            end
        end
    end

    sequence s_fire_bin;
        fire && is_bin && clk_en;
    endsequence
    sequence s_fire_bcd;
        fire && is_bcd && clk_en;
    endsequence
    // edge form written again while its condition is still held
    sequence s_held_edge;
        cmd_wr && nxt_edge && cond_prev_ff && clk_en;
    endsequence

    a_zero_flag_tracks: assert property (@(posedge hclk) disable iff (!hresetn)
        (fire && (is_bin || is_bcd) && clk_en) |=> (flags_ff.zero == (result_ff == 32'h0)))
        else $error("zero flag disagrees with result");
    a_bin_err_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        s_fire_bin |=> !flags_ff.err)
        else $error("binary add left error set");
    a_neg_msb: assert property (@(posedge hclk) disable iff (!hresetn)
        s_fire_bin |=> (flags_ff.neg == (dbl_q ? result_ff[31] : result_ff[15])))
        else $error("negative flag not top bit");
    a_clc_clears: assert property (@(posedge hclk) disable iff (!hresetn)
        (fire && is_clc && clk_en) |=> (!flags_ff.carry && $stable(result_ff)))
        else $error("clear carry did not clear");
    a_single_upper_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        (fire && (is_bin || is_bcd) && clk_en && !dbl) |=> (result_ff[31:16] == 16'h0))
        else $error("single word result spilled");
    a_bin_sum_value: assert property (@(posedge hclk) disable iff (!hresetn)
        (s_fire_bin ##0 dbl) |=> ({flags_ff.carry, result_ff} ==
            $past({1'b0, wa}) + $past({1'b0, wb}) + {32'h0, $past(use_cy && flags_ff.carry)}))
        else $error("double binary sum wrong");
    a_single_sum_value: assert property (@(posedge hclk) disable iff (!hresetn)
        (s_fire_bin ##0 !dbl) |=> ({flags_ff.carry, result_ff[15:0]} ==
            $past({1'b0, wa[15:0]}) + $past({1'b0, wb[15:0]}) + {16'h0, $past(use_cy && flags_ff.carry)}))
        else $error("single binary sum wrong");
    a_ovf_signs: assert property (@(posedge hclk) disable iff (!hresetn)
        s_fire_bin |=> !(flags_ff.ovf && flags_ff.unf))
        else $error("overflow and underflow together");
    a_bcd_err: assert property (@(posedge hclk) disable iff (!hresetn)
        (s_fire_bcd ##0 (|dbad[3:0])) |=> flags_ff.err)
        else $error("bad digit not flagged");
    a_bcd_digits: assert property (@(posedge hclk) disable iff (!hresetn)
        (s_fire_bcd ##0 !(|dbad)) |=> res_dec_ok)
        else $error("decimal result holds a non-digit");
    a_sub_holds: assert property (@(posedge hclk) disable iff (!hresetn)
        (fire && is_sub && clk_en) |=> (sub_ff && $stable(result_ff) && $stable(flags_ff)))
        else $error("subtract changed result or flags");
    a_edge_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
        s_held_edge |=> ($stable(result_ff) && $stable(flags_ff)))
        else $error("edge form ran on held condition");
endmodule // bba_adder_top

// [bba_seq_model.sv]
// sequencer-side model: AHB-Lite master transfers into the adder datapath
`timescale 1ns/1ps
module bba_seq_model (
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [7:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    import bba_pkg::*;
    initial begin
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = HSIZE_WORD;
        hwdata = 32'h0000_0000;
    end
    // -------------------------------------------------
    // single word transfer, entered just after an edge
    // -------------------------------------------------
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata);
        hsel <= 1'b1;
        haddr <= addr;
        hwrite <= wr;
        htrans <= HTRANS_NONSEQ;
        hsize <= HSIZE_WORD;
        // write data is not valid yet, so it must not look stale
        hwdata <= ~hwdata;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wdata;
        do @(posedge hclk); while (hready !== 1'b1);
        rdata = hrdata;
    endtask
endmodule // bba_seq_model

// [testbench.sv]
// self-checking bench for the add-instruction datapath
`timescale 1ns/1ps
module testbench;
    import bba_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic clk_en = 1'b1;
    logic hsel;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic sub_decoded;
    int fail_count = 0;
    int n_tests = 0;
    logic [31:0] rd;
    logic [31:0] exp_res = 32'h0000_0000;
    logic [31:0] res_mask = 32'hFFFF_FFFF;
    logic [5:0] exp_flg = 6'h00;
    logic [5:0] flg_mask = 6'h3F;
    logic exp_sub = 1'b0;
    logic exp_bad = 1'b0;
    logic prev_cond = 1'b0;

    always #2.5 hclk = ~hclk;

    bba_adder_top uut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sub_decoded(sub_decoded));
    bba_seq_model seq (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    // -------------------------------------------------
    // compare, verdict
    // -------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_tests++;
        if (seen !== want) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // -------------------------------------------------
    // reference arithmetic, flags held between commands
    // -------------------------------------------------
    task automatic model_exec(input logic [11:0] op, input logic [31:0] a, input logic [31:0] b);
        logic [32:0] s;
        logic [4:0] d;
        logic c;
        logic bad;
        int tb;
        c = (op == OP_ADC_S || op == OP_ADC_D || op == OP_BCDC_S || op == OP_BCDC_D) ? exp_flg[FLG_CARRY] : 1'b0;
        tb = op[0] ? 31 : 15;
        flg_mask = 6'h3F;
        res_mask = op[0] ? 32'hFFFF_FFFF : 32'h0000_FFFF;
        if (op == OP_CLC) begin
            exp_flg[FLG_CARRY] = 1'b0;
        end else if (op[2] == 1'b0) begin
            s = op[0] ? ({1'b0, a} + {1'b0, b} + c) : ({17'h0, a[15:0]} + {17'h0, b[15:0]} + c);
            exp_res = s[31:0] & res_mask;
            exp_flg[FLG_CARRY] = s[tb + 1];
            exp_flg[FLG_OVF] = !a[tb] && !b[tb] && s[tb];
            exp_flg[FLG_UNF] = a[tb] && b[tb] && !s[tb];
            exp_flg[FLG_NEG] = s[tb];
            exp_flg[FLG_ERR] = 1'b0;
        end else begin
            bad = 1'b0;
            exp_res = 32'h0000_0000;
            for (int i = 0; i < (op[0] ? 8 : 4); i++) begin
                if (a[4*i+:4] > 4'h9 || b[4*i+:4] > 4'h9) bad = 1'b1;
                d = a[4*i+:4] + b[4*i+:4] + c;
                c = d > 5'h09;
                exp_res[4*i+:4] = c ? d[3:0] + 4'h6 : d[3:0];
            end
            exp_flg[FLG_CARRY] = c;
            exp_flg[FLG_ERR] = bad;
            // no result digit and no flag but the error and bad-opcode flags are compared once a nibble is invalid
            if (bad) begin
                flg_mask = 6'h01;
                res_mask = 32'h0000_0000;
            end
        end
        exp_flg[FLG_ZERO] = (exp_res == 32'h0000_0000);
    endtask

    // ce is {condition, edge variant}
    task automatic run(input logic [11:0] op, input logic [31:0] a, input logic [31:0] b, input logic [1:0] ce);
        logic fire;
        seq.xfer(1'b1, ADDR_OPND_A, a, rd);
        seq.xfer(1'b1, ADDR_OPND_B, b, rd);
        seq.xfer(1'b1, ADDR_CMD, {18'h0, ce, op}, rd);
        fire = ce[1] && (!ce[0] || !prev_cond);
        prev_cond = ce[1];
        if (fire) begin
            exp_sub = (op == OP_SUB_S || op == OP_SUB_D);
            exp_bad = !(op inside {OP_ADD_S, OP_ADD_D, OP_ADC_S, OP_ADC_D, OP_BCD_S, OP_BCD_D,
                                   OP_BCDC_S, OP_BCDC_D, OP_SUB_S, OP_SUB_D, OP_CLC});
            if (!exp_sub && !exp_bad) model_exec(op, a, b);
        end
        seq.xfer(1'b0, ADDR_RESULT, 32'h0, rd);
        check(rd & res_mask, exp_res & res_mask);
        seq.xfer(1'b0, ADDR_FLAGS, 32'h0, rd);
        check({25'h0, rd[6:0] & {1'b1, flg_mask}}, {25'h0, exp_bad, exp_flg & flg_mask});
        check({31'h0, sub_decoded}, {31'h0, exp_sub});
        $display("test op=%h cond/edge=%b done", op, ce);
    endtask

    initial begin
        #20000;
        fail_count++;
        stop_test();
    end

    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check({29'h0, sub_decoded, hresp, hreadyout}, 32'h1);
        for (int i = 0; i < 6; i++) begin
            seq.xfer(1'b0, 8'(4 * i), 32'h0, rd);
            check(rd, RESET_WORD);
        end
        // result, flags and a hole take no writes
        for (int i = 3; i < 6; i++) begin
            seq.xfer(1'b1, 8'(4 * i), 32'hFFFF_FFFF, rd);
            seq.xfer(1'b0, 8'(4 * i), 32'h0, rd);
            check(rd, 32'h0000_0000);
        end
        $display("test reset and map done");
        // a transfer while the enable is low must leave no trace
        clk_en <= 1'b0;
        seq.xfer(1'b1, ADDR_OPND_A, 32'h0000_5A5A, rd);
        clk_en <= 1'b1;
        seq.xfer(1'b0, ADDR_OPND_A, 32'h0, rd);
        check(rd, RESET_WORD);
        $display("test clock enable done");
        run(OP_ADD_S, 32'hABCD_1234, 32'h5A5A_4321, 2'b10);
        run(OP_ADD_S, 32'h0000_7FFF, 32'h0000_0001, 2'b10);
        run(OP_ADD_S, 32'h0000_8000, 32'h0000_8000, 2'b10);
        run(OP_ADC_S, 32'h0000_0001, 32'h0000_0001, 2'b10);
        run(OP_ADD_D, 32'h0000_FFFF, 32'h0000_0001, 2'b10);
        run(OP_ADD_D, 32'h7FFF_FFFF, 32'h0000_0001, 2'b10);
        run(OP_ADD_D, 32'h8000_0000, 32'hFFFF_FFFF, 2'b10);
        run(OP_ADC_D, 32'h7FFF_FFFF, 32'h0000_0000, 2'b10);
        run(OP_ADD_S, 32'h0000_FFFF, 32'h0000_0001, 2'b10);
        run(OP_ADC_S, 32'h0000_7FFF, 32'h0000_0000, 2'b10);
        run(OP_ADC_S, 32'h0000_8000, 32'h0000_8000, 2'b10);
        run(OP_ADC_S, 32'h0000_8000, 32'h0000_8000, 2'b10);
        run(OP_CLC, 32'h0000_0000, 32'h0000_0000, 2'b10);
        run(OP_ADC_S, 32'h0000_0001, 32'h0000_0001, 2'b10);
        run(OP_BCD_S, 32'h0000_1234, 32'h0000_8766, 2'b10);
        run(OP_BCDC_S, 32'h0000_0999, 32'h0000_0000, 2'b10);
        run(OP_BCD_D, 32'h9999_9999, 32'h0000_0001, 2'b10);
        run(OP_BCDC_D, 32'h1234_5678, 32'h1111_1111, 2'b10);
        run(OP_BCD_S, 32'h0000_0357, 32'h0000_0468, 2'b10);
        run(OP_BCD_S, 32'h0000_00A0, 32'h0000_0001, 2'b10);
        run(OP_BCD_D, 32'h0000_0001, 32'hF000_0000, 2'b10);
        run(OP_ADD_S, 32'h0000_0001, 32'h0000_0002, 2'b10);
        run(OP_SUB_S, 32'h0000_0009, 32'h0000_0001, 2'b10);
        run(OP_SUB_D, 32'h0000_0009, 32'h0000_0001, 2'b10);
        run(12'h40F, 32'h0000_0001, 32'h0000_0001, 2'b10);
        run(OP_ADD_S, 32'h0000_FFFF, 32'h0000_0001, 2'b10);
        run(OP_ADC_S, 32'h0000_0005, 32'h0000_0000, 2'b11);
        run(OP_ADC_S, 32'h0000_0005, 32'h0000_0000, 2'b00);
        run(OP_ADC_S, 32'h0000_0005, 32'h0000_0000, 2'b11);
        run(OP_ADC_S, 32'h0000_0007, 32'h0000_0000, 2'b11);
        stop_test();
    end
endmodule // testbench
